// [rtl/sttsr_regs.sv]
`timescale 1ns/1ps
// What this block does
// R1: Action 00: ignore timeout, keep regulating
// R2: Action 01: wait delay, shut if persisting
// R3: Action 10: shut down at once, retry
// R4: Action 11 write invalid, flag and alert
// R5: Retry 0: latch off, no restart
// R6: Retry 1-6: restart_wait_period wait, that many restarts
// R7: Retry 7: restart forever until off/success
// R8: Delay 0: no shutdown delay, one-rise restart_wait_period
// R9: Delay n: n ms delay, n-rise restart_wait_period
// R10: Wait turn-off delay after stop request
// R11: Turn-off delay 0-127.5 ms, else invalid
// R12: Small internal delay added to turn-off
// R13: After delay, ramp reference over fall time
// R14: Fall duration independent of output voltage
// R15: Fall 0.5-31.75 ms, below clamps, above invalid
// R16: Fall exponent resets to -2, quarter ms
// R17: Summary bits mirror detailed status sources
// R18: Status byte is the word's low byte
// R19: Busy bit set on busy fault
// R20: Writing 80h clears busy bit
// R21: Off bit live whenever not converting
// R22: Bits 5..0 are fault summaries, reset 0
// R23: Timeout raises status flags and alerts host

// ------
// Quarter-millisecond interval timer
// ------
module sttsr_timer #(
  parameter int QUARTER_CYCLES = sttsr_pkg::QUARTER_MS_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [15:0] target_i,
  output logic done_o
);
  localparam int PRE_W = $clog2(QUARTER_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(QUARTER_CYCLES - 1);

  logic [PRE_W-1:0] pre;
  logic [15:0] quarters;
  logic [15:0] target;
  logic running;

  wire pre_wrap = (pre == PRE_LAST);
  wire reached = running && (quarters == target);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre <= '0;
      quarters <= 16'h0000;
      target <= 16'h0000;
      running <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      pre <= '0;
      quarters <= 16'h0000;
      target <= target_i;
      running <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= reached;
      running <= running && !reached;
      pre <= (running && !pre_wrap) ? pre + PRE_W'(1) : '0;
      quarters <= (running && pre_wrap) ? quarters + 16'h0001 : quarters;
    end
  end
endmodule

// ------
// Register bank and fault, turn-off and status logic
// ------
module sttsr_regs #(
  parameter int QUARTER_CYCLES = sttsr_pkg::QUARTER_MS_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_word_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic invalid_data_o,
  output logic host_alert_o,
  input wire logic nvm_load_i,
  input wire logic [7:0] nvm_response_i,
  input wire logic [15:0] nvm_turnoff_delay_time_i,
  input wire logic [15:0] nvm_soft_off_fall_time_i,
  input wire logic startup_timeout_i,
  input wire logic startup_ok_i,
  input wire logic [11:0] soft_start_rise_time_i,
  input wire logic stop_request_i,
  input wire logic busy_event_i,
  input wire logic output_overvoltage_i,
  input wire logic output_overcurrent_i,
  input wire logic input_undervoltage_i,
  input wire logic temperature_i,
  input wire logic comm_memory_logic_i,
  input wire logic other_fault_i,
  output logic timeout_flag_o,
  output logic fault_shutdown_o,
  output logic restart_o,
  output logic soft_off_active_o,
  output logic [11:0] soft_off_fall_time_o,
  output logic energy_off_o,
  output logic [7:0] summary_fault_byte_o
);

  // ------
  // Registers
  // ------
  logic [7:0] startup_timeout_response;
  logic [15:0] turnoff_delay_time;
  logic [15:0] soft_off_fall_time;
  logic busy_flag;
  logic [5:0] summary_sources;
  logic off_live;
  logic timeout_q;
  logic [2:0] attempts;
  sttsr_pkg::sttsr_fault_state_t fault_state;
  sttsr_pkg::sttsr_fault_state_t next_fault_state;
  sttsr_pkg::sttsr_off_state_t off_state;
  sttsr_pkg::sttsr_off_state_t next_off_state;

  // ------
  // Command decode and write checks
  // ------
  wire wr = cmd_valid_i && cmd_write_i;
  wire rd = cmd_valid_i && !cmd_write_i;
  wire hit_resp = (cmd_code_i == sttsr_pkg::CMD_RESPONSE);
  wire hit_delay = (cmd_code_i == sttsr_pkg::CMD_TURNOFF_DELAY_TIME);
  wire hit_fall = (cmd_code_i == sttsr_pkg::CMD_SOFT_OFF_FALL_TIME);
  wire hit_status = (cmd_code_i == sttsr_pkg::CMD_STATUS_BYTE);

  wire [12:0] wr_lin = sttsr_pkg::sttsr_lin_to_q(cmd_wdata_i);
  wire wr_lin_ok = wr_lin[12];
  wire [11:0] wr_lin_q = wr_lin[11:0];

  wire resp_ok = !cmd_word_i &&
                 (cmd_wdata_i[sttsr_pkg::ACTION_HI:sttsr_pkg::ACTION_LO] != sttsr_pkg::ACTION_INVALID); // [R4]
  wire delay_ok = cmd_word_i && wr_lin_ok && (wr_lin_q <= sttsr_pkg::TURNOFF_DELAY_TIME_MAX_Q); // [R11]
  // Values below the minimum are accepted and stretched later
  wire fall_ok = cmd_word_i && wr_lin_ok && (wr_lin_q <= sttsr_pkg::SOFT_OFF_FALL_TIME_MAX_Q); // [R15]
  wire status_ok = !cmd_word_i;

  wire wr_resp = wr && hit_resp && resp_ok;
  wire wr_delay = wr && hit_delay && delay_ok;
  wire wr_fall = wr && hit_fall && fall_ok;
  wire wr_status = wr && hit_status && status_ok;
  wire wr_bad = wr && ((hit_resp && !resp_ok) || (hit_delay && !delay_ok) ||
                       (hit_fall && !fall_ok) || (hit_status && !status_ok)); // [R4] [R11] [R15]

  // ------
  // Register storage
  // ------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      startup_timeout_response <= sttsr_pkg::RESPONSE_RST;
      turnoff_delay_time <= sttsr_pkg::TURNOFF_DELAY_TIME_RST;
      soft_off_fall_time <= sttsr_pkg::SOFT_OFF_FALL_TIME_RST; // [R16]
    end else if (nvm_load_i) begin
      startup_timeout_response <= nvm_response_i;
      turnoff_delay_time <= nvm_turnoff_delay_time_i;
      soft_off_fall_time <= nvm_soft_off_fall_time_i;
    end else begin
      if (wr_resp) begin
        startup_timeout_response <= cmd_wdata_i[7:0];
      end
      if (wr_delay) begin
        turnoff_delay_time <= cmd_wdata_i;
      end
      if (wr_fall) begin
        soft_off_fall_time <= cmd_wdata_i;
      end
    end
  end

  // ------
  // Field decode
  // ------
  wire [1:0] startup_timeout_action =
    startup_timeout_response[sttsr_pkg::ACTION_HI:sttsr_pkg::ACTION_LO];
  wire [2:0] startup_timeout_retry_count =
    startup_timeout_response[sttsr_pkg::RETRY_HI:sttsr_pkg::RETRY_LO];
  wire [2:0] startup_timeout_shutdown_delay =
    startup_timeout_response[sttsr_pkg::DELAY_HI:sttsr_pkg::DELAY_LO];

  wire [12:0] delay_lin = sttsr_pkg::sttsr_lin_to_q(turnoff_delay_time);
  wire [12:0] fall_lin = sttsr_pkg::sttsr_lin_to_q(soft_off_fall_time);
  // An unusable loaded default behaves as the shortest setting
  wire [11:0] delay_q = delay_lin[12] ? delay_lin[11:0] : 12'h000;
  wire [11:0] fall_raw_q = fall_lin[12] ? fall_lin[11:0] : sttsr_pkg::SOFT_OFF_FALL_TIME_MIN_Q;
  wire [11:0] fall_q = (fall_raw_q < sttsr_pkg::SOFT_OFF_FALL_TIME_MIN_Q) ? sttsr_pkg::SOFT_OFF_FALL_TIME_MIN_Q :
                       (fall_raw_q > sttsr_pkg::SOFT_OFF_FALL_TIME_MAX_Q) ? sttsr_pkg::SOFT_OFF_FALL_TIME_MAX_Q :
                       fall_raw_q; // [R15]

  // Shutdown delay in quarter ms and restart_wait_period as a multiple of the rise time
  wire [15:0] shutdown_q = 16'(startup_timeout_shutdown_delay) * sttsr_pkg::QUARTERS_PER_MS; // [R8] [R9]
  wire [2:0] restart_wait_period_mult = (startup_timeout_shutdown_delay == 3'h0) ? 3'h1 :
                           startup_timeout_shutdown_delay; // [R8] [R9]
  wire [15:0] restart_wait_period_q = 16'(restart_wait_period_mult) * 16'(soft_start_rise_time_i); // [R6]

  // ------
  // Startup-timeout response sequencer
  // ------
  wire timeout_event = startup_timeout_i && !timeout_q && !stop_request_i;
  wire retries_left = (startup_timeout_retry_count == sttsr_pkg::RETRY_FOREVER) ||
                      (attempts < startup_timeout_retry_count); // [R6] [R7]
  wire go_latch = (startup_timeout_retry_count == sttsr_pkg::RETRY_NONE) || !retries_left; // [R5]
  wire delay_now = (startup_timeout_action == sttsr_pkg::ACTION_DELAYED) &&
                   (startup_timeout_shutdown_delay != 3'h0);
  wire shut_now = ((startup_timeout_action == sttsr_pkg::ACTION_IMMEDIATE) ||
                   ((startup_timeout_action == sttsr_pkg::ACTION_DELAYED) &&
                    (startup_timeout_shutdown_delay == 3'h0))); // [R3] [R8]
  logic fault_timer_done;
  logic fault_shutdown_next;

  always_comb begin
    next_fault_state = fault_state;
    unique case (fault_state)
      sttsr_pkg::FLT_WATCH: begin
        // Ignore leaves the sequencer watching and the output regulating
        if (timeout_event && delay_now) begin
          next_fault_state = sttsr_pkg::FLT_DELAY; // [R2]
        end else if (timeout_event && shut_now) begin
          next_fault_state = go_latch ? sttsr_pkg::FLT_LATCHED : sttsr_pkg::FLT_RESTART_WAIT_PERIOD; // [R3] [R5]
        end
      end
      sttsr_pkg::FLT_DELAY: begin
        if (fault_timer_done) begin
          if (!startup_timeout_i) begin
            next_fault_state = sttsr_pkg::FLT_WATCH;
          end else begin
            next_fault_state = go_latch ? sttsr_pkg::FLT_LATCHED : sttsr_pkg::FLT_RESTART_WAIT_PERIOD; // [R2]
          end
        end
      end
      sttsr_pkg::FLT_RESTART_WAIT_PERIOD: begin
        if (fault_timer_done) begin
          next_fault_state = sttsr_pkg::FLT_WATCH; // [R6] [R7]
        end
      end
      sttsr_pkg::FLT_LATCHED: begin
        next_fault_state = sttsr_pkg::FLT_LATCHED; // [R5]
      end
    endcase
    // A commanded stop ends any retry sequence or latch
    if (stop_request_i) begin
      next_fault_state = sttsr_pkg::FLT_WATCH; // [R7]
    end
  end

  wire fault_entering = (next_fault_state != fault_state);
  wire fault_load = fault_entering && ((next_fault_state == sttsr_pkg::FLT_DELAY) ||
                                       (next_fault_state == sttsr_pkg::FLT_RESTART_WAIT_PERIOD));
  wire [15:0] fault_target = (next_fault_state == sttsr_pkg::FLT_DELAY) ? shutdown_q : restart_wait_period_q;
  wire restart_now = (fault_state == sttsr_pkg::FLT_RESTART_WAIT_PERIOD) && fault_timer_done && !stop_request_i;
  assign fault_shutdown_next = (next_fault_state == sttsr_pkg::FLT_RESTART_WAIT_PERIOD) ||
                               (next_fault_state == sttsr_pkg::FLT_LATCHED);

  sttsr_timer #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_fault_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .load_i(fault_load),
    .target_i(fault_target),
    .done_o(fault_timer_done)
  );

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_state <= sttsr_pkg::FLT_WATCH;
      attempts <= 3'h0;
      timeout_q <= 1'b0;
    end else begin
      fault_state <= next_fault_state;
      timeout_q <= startup_timeout_i;
      if (stop_request_i || startup_ok_i) begin
        attempts <= 3'h0; // [R7]
      end else if (restart_now && (attempts != 3'h7)) begin
        attempts <= attempts + 3'h1; // [R6]
      end
    end
  end

  // ------
  // Turn-off sequencer
  // ------
  logic off_timer_done;

  always_comb begin
    next_off_state = off_state;
    unique case (off_state)
      sttsr_pkg::OFF_RUN: begin
        if (stop_request_i) begin
          next_off_state = sttsr_pkg::OFF_DELAY; // [R10]
        end
      end
      sttsr_pkg::OFF_DELAY: begin
        if (off_timer_done) begin
          next_off_state = sttsr_pkg::OFF_FALL; // [R13]
        end
      end
      sttsr_pkg::OFF_FALL: begin
        if (off_timer_done) begin
          next_off_state = sttsr_pkg::OFF_DONE; // [R13]
        end
      end
      sttsr_pkg::OFF_DONE: begin
        next_off_state = sttsr_pkg::OFF_DONE;
      end
    endcase
    if (!stop_request_i) begin
      next_off_state = sttsr_pkg::OFF_RUN;
    end
  end

  // The timer's load and done pulses add a few cycles, well inside the allowed margin
  wire off_load = (next_off_state != off_state) && ((next_off_state == sttsr_pkg::OFF_DELAY) ||
                                                   (next_off_state == sttsr_pkg::OFF_FALL)); // [R12]
  // Fall duration depends only on the programmed time, never on the setpoint
  wire [15:0] off_target = (next_off_state == sttsr_pkg::OFF_DELAY) ? 16'(delay_q) : 16'(fall_q); // [R14]

  sttsr_timer #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_off_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .load_i(off_load),
    .target_i(off_target),
    .done_o(off_timer_done)
  );

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      off_state <= sttsr_pkg::OFF_RUN;
    end else begin
      off_state <= next_off_state;
    end
  end

  // ------
  // Summary status
  // ------
  wire converting_next = !fault_shutdown_next && (next_off_state != sttsr_pkg::OFF_DONE);
  wire busy_clear = wr_status && cmd_wdata_i[sttsr_pkg::BUSY_BIT];
  wire [7:0] status_byte = {busy_flag, off_live, summary_sources}; // [R18]

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_flag <= 1'b0;
      summary_sources <= 6'h00; // [R22]
      off_live <= 1'b0;
    end else begin
      // A busy event in the clearing cycle keeps the flag set
      busy_flag <= busy_event_i || (busy_flag && !busy_clear); // [R19] [R20]
      summary_sources <= {output_overvoltage_i, output_overcurrent_i, input_undervoltage_i,
                          temperature_i, comm_memory_logic_i, other_fault_i}; // [R17] [R22]
      off_live <= !converting_next; // [R21]
    end
  end

  // ------
  // Read data and outputs
  // ------
  wire [15:0] read_mux = hit_resp ? {8'h00, startup_timeout_response} :
                         hit_delay ? turnoff_delay_time :
                         hit_fall ? soft_off_fall_time :
                         hit_status ? {8'h00, status_byte} : 16'h0000;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      invalid_data_o <= 1'b0;
      host_alert_o <= 1'b0;
      timeout_flag_o <= 1'b0;
      fault_shutdown_o <= 1'b0;
      restart_o <= 1'b0;
      soft_off_active_o <= 1'b0;
      soft_off_fall_time_o <= sttsr_pkg::SOFT_OFF_FALL_TIME_MIN_Q;
      energy_off_o <= 1'b0;
      summary_fault_byte_o <= sttsr_pkg::STATUS_RST;
    end else begin
      rsp_valid_o <= rd;
      rsp_data_o <= rd ? read_mux : rsp_data_o;
      invalid_data_o <= wr_bad; // [R4] [R11] [R15]
      host_alert_o <= wr_bad || timeout_event; // [R4] [R23]
      timeout_flag_o <= timeout_event; // [R23]
      fault_shutdown_o <= fault_shutdown_next; // [R3] [R5]
      restart_o <= restart_now; // [R6] [R7]
      soft_off_active_o <= (next_off_state == sttsr_pkg::OFF_FALL); // [R13]
      soft_off_fall_time_o <= fall_q; // [R14]
      energy_off_o <= (next_off_state == sttsr_pkg::OFF_DONE); // [R10]
      summary_fault_byte_o <= status_byte; // [R18]
    end
  end

endmodule

// [rtl/sttsr_pkg.sv]
package sttsr_pkg;

  // ------
  // Command codes
  // ------
  localparam logic [7:0] CMD_RESPONSE = 8'h63;
  localparam logic [7:0] CMD_TURNOFF_DELAY_TIME = 8'h64;
  localparam logic [7:0] CMD_SOFT_OFF_FALL_TIME = 8'h65;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;

  // ------
  // Field positions
  // ------
  localparam int ACTION_HI = 7;
  localparam int ACTION_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MAN_HI = 10;
  localparam int MAN_LO = 0;
  localparam int BUSY_BIT = 7;
  localparam int OFF_BIT = 6;

  // ------
  // Encodings and values after reset
  // ------
  localparam logic [1:0] ACTION_IGNORE = 2'h0;
  localparam logic [1:0] ACTION_DELAYED = 2'h1;
  localparam logic [1:0] ACTION_IMMEDIATE = 2'h2;
  localparam logic [1:0] ACTION_INVALID = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [4:0] EXP_QUARTER_MS = 5'h1E;
  localparam logic [4:0] EXP_HALF_MS = 5'h1F;
  localparam logic [7:0] RESPONSE_RST = 8'h00;
  localparam logic [15:0] TURNOFF_DELAY_TIME_RST = 16'hF800;
  localparam logic [15:0] SOFT_OFF_FALL_TIME_RST = 16'hF000;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ------
  // Ranges, in quarter milliseconds
  // ------
  localparam logic [11:0] TURNOFF_DELAY_TIME_MAX_Q = 12'h1FE;
  localparam logic [11:0] SOFT_OFF_FALL_TIME_MAX_Q = 12'h07F;
  localparam logic [11:0] SOFT_OFF_FALL_TIME_MIN_Q = 12'h002;
  localparam logic [15:0] QUARTERS_PER_MS = 16'h0004;

  // ------
  // Timing
  // ------
  localparam int CLK_PERIOD_NS = 5;
  localparam int QUARTER_MS_NS = 250000;
  localparam int QUARTER_MS_CYCLES = QUARTER_MS_NS / CLK_PERIOD_NS;

  // ------
  // States
  // ------
  typedef enum logic [1:0] {
    FLT_WATCH = 2'b00,
    FLT_DELAY = 2'b01,
    FLT_RESTART_WAIT_PERIOD = 2'b10,
    FLT_LATCHED = 2'b11
  } sttsr_fault_state_t;

  typedef enum logic [1:0] {
    OFF_RUN = 2'b00,
    OFF_DELAY = 2'b01,
    OFF_FALL = 2'b10,
    OFF_DONE = 2'b11
  } sttsr_off_state_t;

  // Linear word to quarter milliseconds; bit 12 is set when the value is usable
  function automatic logic [12:0] sttsr_lin_to_q(input logic [15:0] value);
    logic [4:0] exp;
    logic [10:0] man;
    logic [12:0] result;
    exp = value[EXP_HI:EXP_LO];
    man = value[MAN_HI:MAN_LO];
    result = 13'h0000;
    if (!man[10]) begin
      if (exp == EXP_QUARTER_MS) begin
        result = {1'b1, 1'b0, man};
      end else if (exp == EXP_HALF_MS) begin
        result = {1'b1, man, 1'b0};
      end
    end
    return result;
  endfunction

endpackage

// [verif/sttsr_regs_monitor.sv]
`timescale 1ns/1ps
module sttsr_regs_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_word_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic invalid_data_o,
  input wire logic host_alert_o,
  input wire logic startup_timeout_i,
  input wire logic stop_request_i,
  input wire logic busy_event_i,
  input wire logic output_overvoltage_i,
  input wire logic output_overcurrent_i,
  input wire logic input_undervoltage_i,
  input wire logic temperature_i,
  input wire logic comm_memory_logic_i,
  input wire logic other_fault_i,
  input wire logic timeout_flag_o,
  input wire logic fault_shutdown_o,
  input wire logic restart_o,
  input wire logic energy_off_o,
  input wire logic [11:0] soft_off_fall_time_o,
  input wire logic [7:0] summary_fault_byte_o
);
  // ------
  // Checks
  // ------
  // The byte output lags its status register by one more cycle
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire wr_tk;
  assign wr_tk = cmd_valid_i && cmd_write_i;
  property p_act;
    wr_tk && !cmd_word_i && cmd_code_i == 8'h63 && cmd_wdata_i[7:6] == 2'h3 |=> invalid_data_o && host_alert_o;
  endproperty
  a_act: assert property (p_act) else $error("bad action accepted");
  property p_dly;
    wr_tk && cmd_word_i && cmd_code_i == 8'h64 && cmd_wdata_i[15:11] == 5'h1F && cmd_wdata_i[10:8] != 3'h0
      |=> invalid_data_o;
  endproperty
  a_dly: assert property (p_dly) else $error("long delay accepted");
  property p_fall;
    wr_tk && cmd_word_i && cmd_code_i == 8'h65 && cmd_wdata_i[15:11] == 5'h1E && cmd_wdata_i[10:7] != 4'h0
      |=> invalid_data_o;
  endproperty
  a_fall: assert property (p_fall) else $error("long fall accepted");
  property p_clamp;
    soft_off_fall_time_o >= 12'h002 && soft_off_fall_time_o <= 12'h07F;
  endproperty
  a_clamp: assert property (p_clamp) else $error("fall time out of range");
  property p_off;
    summary_fault_byte_o[6] == $past(fault_shutdown_o || energy_off_o);
  endproperty
  a_off: assert property (p_off) else $error("off bit not live");
  property p_sum;
    !$past(reset_i, 2) |-> summary_fault_byte_o[5:0] == $past({output_overvoltage_i, output_overcurrent_i,
      input_undervoltage_i, temperature_i, comm_memory_logic_i, other_fault_i}, 2);
  endproperty
  a_sum: assert property (p_sum) else $error("summary bits wrong");
  property p_bset;
    busy_event_i |-> ##2 summary_fault_byte_o[7];
  endproperty
  a_bset: assert property (p_bset) else $error("busy not set");
  property p_bclr;
    wr_tk && !cmd_word_i && cmd_code_i == 8'h78 && cmd_wdata_i[7] && !busy_event_i
      |-> ##2 !summary_fault_byte_o[7];
  endproperty
  a_bclr: assert property (p_bclr) else $error("busy not cleared");
  property p_tmo;
    $rose(startup_timeout_i) && !stop_request_i |=> timeout_flag_o && host_alert_o;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not flagged");
  property p_rst;
    restart_o |-> !fault_shutdown_o;
  endproperty
  a_rst: assert property (p_rst) else $error("restart while shut");
  c_rst: cover property (restart_o);
  c_off: cover property (energy_off_o);
  c_bad: cover property (invalid_data_o);
endmodule

bind sttsr_regs sttsr_regs_monitor i_mon (.*);

// [verif/sttsr_host.sv]
`timescale 1ns/1ps
module sttsr_host (
  input wire logic sys_clk_i,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i,
  input wire logic invalid_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic cmd_word_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_wdata_o
);
  // ------
  // Host transactions, one per call
  // ------
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_word_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  task automatic xfer(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rd, output logic bad);
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_word_o <= wd;
    cmd_code_o <= c;
    cmd_wdata_o <= d;
    @(posedge sys_clk_i);
    // Released lines move away so stale data cannot pass as valid
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~c;
    cmd_wdata_o <= ~d;
    #1;
    rd = rsp_valid_i ? rsp_data_i : 16'hXXXX;
    bad = invalid_i;
  endtask
endmodule

// [verif/startup_timeout_turnoff_status_regs_test.sv]
`timescale 1ns/1ps
module startup_timeout_turnoff_status_regs_test;
  logic sys_clk_i, reset_i, cmd_valid_i, cmd_write_i, cmd_word_i, nvm_load_i, rsp_valid_o, invalid_data_o;
  logic host_alert_o, startup_timeout_i, startup_ok_i, stop_request_i, busy_event_i, output_overvoltage_i;
  logic output_overcurrent_i, input_undervoltage_i, temperature_i, comm_memory_logic_i, other_fault_i;
  logic timeout_flag_o, fault_shutdown_o, restart_o, soft_off_active_o, energy_off_o, bad;
  logic [7:0] cmd_code_i, nvm_response_i, summary_fault_byte_o;
  logic [15:0] cmd_wdata_i, rsp_data_o, nvm_turnoff_delay_time_i, nvm_soft_off_fall_time_i, rd;
  logic [11:0] soft_start_rise_time_i, soft_off_fall_time_o;
  int err_total, comparisons, n_rst, n_soft;
  sttsr_regs #(.QUARTER_CYCLES(4)) i_dut (.*);
  sttsr_host i_host (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .invalid_i(invalid_data_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_word_o(cmd_word_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));
  // ------
  // Helpers
  // ------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic run(input int k);
    n_rst = 0;
    n_soft = 0;
    repeat (k) begin
      @(posedge sys_clk_i);
      #1;
      n_rst += restart_o;
      n_soft += soft_off_active_o;
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d, input logic e);
    i_host.xfer(1'b1, w, c, d, rd, bad);
    chk("invalid_data", {15'h0000, e}, {15'h0000, bad});
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    // Codes 64h and 65h are the word registers
    i_host.xfer(1'b0, c[2], c, 16'h0000, rd, bad);
    chk("read_data", e, rd);
  endtask
  task automatic evt();
    @(posedge sys_clk_i);
    {startup_timeout_i, startup_ok_i} <= 2'h0;
    @(posedge sys_clk_i);
    startup_timeout_i <= 1'b1;
    run(1);
    chk("timeout_flag", 16'h0001, {15'h0000, timeout_flag_o});
  endtask
  task automatic clr();
    @(posedge sys_clk_i);
    startup_timeout_i <= 1'b0;
    stop_request_i <= 1'b1;
    run(3);
    stop_request_i <= 1'b0;
    run(3);
  endtask
  task automatic hic(input logic [7:0] r, input int q, input int m, input logic fs, input logic ok);
    wr(8'h63, 1'b0, {8'h00, r}, 1'b0);
    evt();
    run(q);
    chk("restart_early", 16'h0000, n_rst[15:0]);
    chk("shutdown", {15'h0000, fs}, {15'h0000, fault_shutdown_o});
    run(m);
    chk("restart", 16'h0001, n_rst[15:0]);
    startup_ok_i <= ok;
    evt();
    run(40);
    chk("retry_limit", ok || r[5:3] == 3'h7 ? 16'h0002 : 16'h0001, {n_rst[14:0], fault_shutdown_o});
    clr();
  endtask
  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {reset_i, nvm_load_i, startup_ok_i, stop_request_i, busy_event_i, startup_timeout_i} = 6'h20;
    {output_overvoltage_i, output_overcurrent_i, input_undervoltage_i} = 3'h0;
    {temperature_i, comm_memory_logic_i, other_fault_i} = 3'h0;
    {nvm_response_i, nvm_turnoff_delay_time_i, nvm_soft_off_fall_time_i} = 40'h0000000000;
    soft_start_rise_time_i = 12'h002;
    err_total = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rdc(8'h63, 16'h0000);
    rdc(8'h64, 16'hF800);
    rdc(8'h65, 16'hF000);
    rdc(8'h78, 16'h0000);
    rdc(8'h10, 16'h0000);
    $display("test reset_values done");
    wr(8'h63, 1'b0, 16'h00C0, 1'b1);
    rdc(8'h63, 16'h0000);
    wr(8'h64, 1'b1, 16'hF9FF, 1'b1);
    wr(8'h64, 1'b1, 16'hF1FF, 1'b1);
    wr(8'h64, 1'b1, 16'hF1FE, 1'b0);
    rdc(8'h64, 16'hF1FE);
    wr(8'h65, 1'b1, 16'hF080, 1'b1);
    wr(8'h65, 1'b1, 16'hF07F, 1'b0);
    run(2);
    chk("fall_time", 16'h007F, {4'h0, soft_off_fall_time_o});
    wr(8'h65, 1'b1, 16'hF001, 1'b0);
    run(2);
    chk("fall_time", 16'h0002, {4'h0, soft_off_fall_time_o});
    rdc(8'h65, 16'hF001);
    $display("test ranges done");
    @(posedge sys_clk_i);
    {output_overvoltage_i, input_undervoltage_i, temperature_i, other_fault_i} <= 4'hF;
    busy_event_i <= 1'b1;
    @(posedge sys_clk_i);
    busy_event_i <= 1'b0;
    run(2);
    rdc(8'h78, 16'h00AD);
    chk("status_byte", 16'h00AD, {8'h00, summary_fault_byte_o});
    wr(8'h78, 1'b0, 16'h0080, 1'b0);
    run(1);
    chk("busy", 16'h0000, {15'h0000, summary_fault_byte_o[7]});
    {output_overvoltage_i, input_undervoltage_i, temperature_i, other_fault_i} <= 4'h0;
    $display("test status done");
    wr(8'h63, 1'b0, 16'h0000, 1'b0);
    evt();
    run(40);
    chk("ignore", 16'h0000, {15'h0000, fault_shutdown_o});
    clr();
    wr(8'h63, 1'b0, 16'h0080, 1'b0);
    evt();
    run(40);
    chk("latch", 16'h0001, {n_rst[14:0], fault_shutdown_o});
    chk("off_bit", 16'h0001, {15'h0000, summary_fault_byte_o[6]});
    clr();
    hic(8'h88, 6, 20, 1'b1, 1'b0);
    hic(8'h8B, 20, 20, 1'b1, 1'b0);
    hic(8'h49, 12, 30, 1'b0, 1'b0);
    hic(8'hB8, 6, 20, 1'b1, 1'b0);
    hic(8'h88, 6, 20, 1'b1, 1'b1);
    $display("test startup_timeout done");
    wr(8'h64, 1'b1, 16'hF802, 1'b0);
    stop_request_i <= 1'b1;
    run(8);
    chk("early_off", 16'h0000, {14'h0000, soft_off_active_o, energy_off_o});
    run(40);
    chk("fall_len", 16'h0001, {15'h0000, n_soft >= 8 && n_soft <= 12});
    chk("energy_off", 16'h0003, {14'h0000, energy_off_o, summary_fault_byte_o[6]});
    stop_request_i <= 1'b0;
    run(3);
    $display("test turn_off done");
    test_done();
  end
endmodule
